/* isdnf_cfg.svh */
`ifndef ISDNF_CFG_SVH
`define ISDNF_CFG_SVH

// ****************************************************************
// Frame positions, numbered from one.
// ****************************************************************
`define ISDNF_POS_FIRST  6'h01
`define ISDNF_POS_FBAL   6'h02
`define ISDNF_POS_B1A    6'h03
`define ISDNF_POS_E1     6'h0B
`define ISDNF_POS_D1     6'h0C
`define ISDNF_POS_A      6'h0D
`define ISDNF_POS_FA     6'h0E
`define ISDNF_POS_N      6'h0F
`define ISDNF_POS_B2A    6'h10
`define ISDNF_POS_E2     6'h18
`define ISDNF_POS_D2     6'h19
`define ISDNF_POS_M      6'h1A
`define ISDNF_POS_B1B    6'h1B
`define ISDNF_POS_E3     6'h23
`define ISDNF_POS_D3     6'h24
`define ISDNF_POS_S      6'h25
`define ISDNF_POS_B2B    6'h26
`define ISDNF_POS_E4     6'h2E
`define ISDNF_POS_D4     6'h2F
`define ISDNF_POS_LAST   6'h30
`define ISDNF_OCT_SPAN   6'h07
`define ISDNF_RX_OFFSET  6'h02
`define ISDNF_RX_WRAP    6'h2E

// ****************************************************************
// Reset values and timing.
// ****************************************************************
`define ISDNF_ECHO_RST   1'h1
`define ISDNF_CLK_KHZ    40000
`define ISDNF_BIT_KBPS   192
`define ISDNF_CYC_PER_BIT (`ISDNF_CLK_KHZ / `ISDNF_BIT_KBPS)
`define ISDNF_LOSS_CYC   (2 * `ISDNF_CYC_PER_BIT)
`endif

/* isdnf_coder.sv */
`timescale 1ns/1ps
`include "isdnf_cfg.svh"
module isdnf_coder (
    // Clock and reset.
    input  wire logic              clk,
    input  wire logic              resetn,
    // Bit to code.
    input  wire logic              stb,
    input  wire logic              data,
    input  wire logic              bal,
    input  wire logic              fbal,
    // Coded symbol.
    output isdnf_pkg::isdnf_sym_t  sym_r
);
    import isdnf_pkg::*;

    logic par_r;
    logic last_neg_r;
    logic after_fbal_r;
    logic bit_v;
    logic neg_v;

    // Balance bits are computed here, data bits pass through.
    always_comb begin
        bit_v = bal ? ~par_r : data;
        neg_v = after_fbal_r ? last_neg_r : ~last_neg_r;
    end

    // Symbol output and polarity memory.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sym_r      <= ISDNF_SYM_NONE;
            last_neg_r <= 1'h0;
        end else if (stb) begin
            if (!bit_v) begin
                sym_r      <= neg_v ? ISDNF_SYM_NEG : ISDNF_SYM_POS;
                last_neg_r <= neg_v;
            end else begin
                sym_r <= ISDNF_SYM_NONE;
            end
        end
    end

    // Parity of ZEROs since the last balance bit.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            par_r <= 1'h0;
        end else if (stb) begin
            par_r <= bal ? 1'h0 : (par_r ^ ~bit_v);
        end
    end

    // Marks the window up to the first ZERO after framing balance.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            after_fbal_r <= 1'h0;
        end else if (stb) begin
            if (fbal) begin
                after_fbal_r <= 1'h1;
            end else if (!bit_v) begin
                after_fbal_r <= 1'h0;
            end
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    AST_ONE_IS_SILENT: assert property (stb && bit_v |=> sym_r == ISDNF_SYM_NONE)
        else $error("ONE not sent as silence");
    AST_ALTERNATE: assert property (stb && !bit_v && !after_fbal_r && !bal
        |=> (sym_r == ISDNF_SYM_NEG) == !$past(last_neg_r))
        else $error("ZERO did not alternate");
    AST_FBAL_REPEAT: assert property (stb && !bit_v && after_fbal_r
        |=> (sym_r == ISDNF_SYM_NEG) == $past(last_neg_r))
        else $error("first ZERO after framing balance changed polarity");
    AST_BALANCE: assert property (stb && bal
        |=> (sym_r == ISDNF_SYM_NONE) == !$past(par_r))
        else $error("balance bit wrong for ZERO count");
endmodule

/* isdnf_nt.sv */
`timescale 1ns/1ps
`include "isdnf_cfg.svh"
module isdnf_nt (
    // Clock and reset.
    input  wire logic               clk,
    input  wire logic               resetn,
    // Network bit clock and line pins.
    input  wire logic               net_bclk,
    input  wire logic [1:0]         line_rx,
    output isdnf_pkg::isdnf_sym_t   line_tx,
    // Transmit payload and control.
    input  isdnf_pkg::isdnf_txfr_t  tx_frame,
    input  isdnf_pkg::isdnf_ctl_t   tx_ctl,
    output logic                    frame_tick,
    // Receive payload and status.
    output isdnf_pkg::isdnf_rxfr_t  rx_frame,
    output logic                    rx_valid,
    output logic                    rx_sync,
    output logic                    code_err,
    output logic                    clk_lost
);
    import isdnf_pkg::*;

    // ****************************************************************
    // Declarations.
    // ****************************************************************
    logic        bclk_s1_r;
    logic        bclk_s2_r;
    logic        bclk_s3_r;
    logic [1:0]  rx_s1_r;
    logic [1:0]  rx_s2_r;
    logic        bit_stb;
    logic [5:0]  tx_pos_r;
    logic [5:0]  rx_pos;
    isdnf_txfr_t frm_r;
    isdnf_ctl_t  ctl_r;
    logic        echo_r;
    logic        tx_bit;
    logic        is_bal;
    logic        is_fbal;
    logic        frame_tick_r;
    logic [9:0]  wd_cnt_r;
    logic        clk_lost_r;
    logic        rx_zero;
    logic        rx_neg;
    logic        rx_bit;
    logic        rx_viol;
    logic        rx_frame_pos;
    logic        have_pol_r;
    logic        rx_last_neg_r;
    logic        expect_fv_r;
    isdnf_rxst_t rx_state_r;
    isdnf_rxst_t rx_state_nxt;
    isdnf_rxfr_t rx_acc_r;
    isdnf_rxfr_t rx_frame_r;
    logic        rx_valid_r;
    logic        code_err_r;

    // Selects the bit sent at a frame position.
    function automatic logic tx_bit_f(input logic [5:0] p, input isdnf_txfr_t f,
                                      input isdnf_ctl_t c, input logic e);
        logic v;
        v = 1'h1;
        if (p >= `ISDNF_POS_B1A && p <= `ISDNF_POS_B1A + `ISDNF_OCT_SPAN) begin
            v = f.b1_first[3'(`ISDNF_POS_B1A + `ISDNF_OCT_SPAN - p)];
        end else if (p >= `ISDNF_POS_B2A && p <= `ISDNF_POS_B2A + `ISDNF_OCT_SPAN) begin
            v = f.b2_first[3'(`ISDNF_POS_B2A + `ISDNF_OCT_SPAN - p)];
        end else if (p >= `ISDNF_POS_B1B && p <= `ISDNF_POS_B1B + `ISDNF_OCT_SPAN) begin
            v = f.b1_second[3'(`ISDNF_POS_B1B + `ISDNF_OCT_SPAN - p)];
        end else if (p >= `ISDNF_POS_B2B && p <= `ISDNF_POS_B2B + `ISDNF_OCT_SPAN) begin
            v = f.b2_second[3'(`ISDNF_POS_B2B + `ISDNF_OCT_SPAN - p)];
        end else if (p == `ISDNF_POS_E1 || p == `ISDNF_POS_E2 ||
                     p == `ISDNF_POS_E3 || p == `ISDNF_POS_E4) begin
            v = e & ~c.echo_zero;
        end else if (p == `ISDNF_POS_D1) begin
            v = f.d[3];
        end else if (p == `ISDNF_POS_D2) begin
            v = f.d[2];
        end else if (p == `ISDNF_POS_D3) begin
            v = f.d[1];
        end else if (p == `ISDNF_POS_D4) begin
            v = f.d[0];
        end else if (p == `ISDNF_POS_A) begin
            v = f.act;
        end else if (p == `ISDNF_POS_FA) begin
            v = c.mf_en & c.fa;
        end else if (p == `ISDNF_POS_N) begin
            v = ~(c.mf_en & c.fa);
        end else if (p == `ISDNF_POS_M) begin
            v = c.mf_en & c.m;
        end else if (p == `ISDNF_POS_S) begin
            v = 1'h0;
        end else if (p == `ISDNF_POS_FIRST) begin
            v = 1'h0;
        end
        return v;
    endfunction

    // ****************************************************************
    // Network clock and line input synchronisers.
    // ****************************************************************
    // Two stages for each pin, a third for the edge detector.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            bclk_s1_r <= 1'h0;
            bclk_s2_r <= 1'h0;
            bclk_s3_r <= 1'h0;
            rx_s1_r   <= 2'h0;
            rx_s2_r   <= 2'h0;
        end else begin
            bclk_s1_r <= net_bclk;
            bclk_s2_r <= bclk_s1_r;
            bclk_s3_r <= bclk_s2_r;
            rx_s1_r   <= line_rx;
            rx_s2_r   <= rx_s1_r;
        end
    end

    // One bit period starts on each rising network clock edge.
    assign bit_stb = bclk_s2_r & ~bclk_s3_r;

    // Flags a network clock that stops for two bit periods.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wd_cnt_r   <= 10'h000;
            clk_lost_r <= 1'h0;
        end else if (bit_stb) begin
            wd_cnt_r   <= 10'h000;
            clk_lost_r <= 1'h0;
        end else if (wd_cnt_r >= 10'(`ISDNF_LOSS_CYC)) begin
            clk_lost_r <= 1'h1;
        end else begin
            wd_cnt_r <= wd_cnt_r + 10'h001;
        end
    end

    // ****************************************************************
    // Transmit framing.
    // ****************************************************************
    // Frame position counter and payload latch at each frame end.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            tx_pos_r     <= `ISDNF_POS_FIRST;
            frm_r        <= '0;
            ctl_r        <= '0;
            frame_tick_r <= 1'h0;
        end else begin
            frame_tick_r <= 1'h0;
            if (bit_stb) begin
                if (tx_pos_r == `ISDNF_POS_LAST) begin
                    tx_pos_r     <= `ISDNF_POS_FIRST;
                    frm_r        <= tx_frame;
                    ctl_r        <= tx_ctl;
                    frame_tick_r <= 1'h1;
                end else begin
                    tx_pos_r <= tx_pos_r + 6'h01;
                end
            end
        end
    end

    // Bit selection and balance positions for the coder.
    always_comb begin
        tx_bit  = tx_bit_f(tx_pos_r, frm_r, ctl_r, echo_r);
        is_fbal = (tx_pos_r == `ISDNF_POS_FBAL);
        is_bal  = is_fbal || (tx_pos_r == `ISDNF_POS_LAST);
    end

    // Line coder for the outgoing stream.
    isdnf_coder u_coder (
        .clk    (clk),
        .resetn (resetn),
        .stb    (bit_stb),
        .data   (tx_bit),
        .bal    (is_bal),
        .fbal   (is_fbal),
        .sym_r  (line_tx)
    );

    // ****************************************************************
    // Receive decoding.
    // ****************************************************************

    // The TE frame lags the outgoing frame by two bit periods.
    always_comb begin
        rx_pos = (tx_pos_r > `ISDNF_RX_OFFSET) ? (tx_pos_r - `ISDNF_RX_OFFSET)
                                               : (tx_pos_r + `ISDNF_RX_WRAP);
        rx_zero      = (rx_s2_r == ISDNF_SYM_POS) || (rx_s2_r == ISDNF_SYM_NEG);
        rx_neg       = (rx_s2_r == ISDNF_SYM_NEG);
        rx_bit       = ~rx_zero;
        rx_viol      = rx_zero && have_pol_r && (rx_neg == rx_last_neg_r);
        rx_frame_pos = (rx_pos <= `ISDNF_POS_FBAL) || expect_fv_r;
    end

    // Polarity history and framing violation window.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            have_pol_r    <= 1'h0;
            rx_last_neg_r <= 1'h0;
            expect_fv_r   <= 1'h0;
        end else if (bit_stb) begin
            if (rx_zero) begin
                have_pol_r    <= 1'h1;
                rx_last_neg_r <= rx_neg;
            end
            if (rx_pos == `ISDNF_POS_FBAL) begin
                expect_fv_r <= 1'h1;
            end else if (rx_zero) begin
                expect_fv_r <= 1'h0;
            end
        end
    end

    // Alignment checks against the expected framing violation.
    always_comb begin
        rx_state_nxt = rx_state_r;
        case (rx_state_r)
            ISDNF_RX_HUNT: begin
                if (bit_stb && expect_fv_r && rx_viol) begin
                    rx_state_nxt = ISDNF_RX_SYNC;
                end
            end
            ISDNF_RX_SYNC: begin
                if (bit_stb && expect_fv_r && rx_zero && !rx_viol) begin
                    rx_state_nxt = ISDNF_RX_HUNT;
                end
            end
            default: begin
                rx_state_nxt = ISDNF_RX_HUNT;
            end
        endcase
    end

    // Alignment state register.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rx_state_r <= ISDNF_RX_HUNT;
        end else begin
            rx_state_r <= rx_state_nxt;
        end
    end

    // Violation outside the framing window is a code error.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            code_err_r <= 1'h0;
        end else begin
            code_err_r <= bit_stb && rx_viol && !rx_frame_pos;
        end
    end

    // Received D bits are copied to the next echo position.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            echo_r <= `ISDNF_ECHO_RST;
        end else if (bit_stb && (rx_pos == `ISDNF_POS_D1 || rx_pos == `ISDNF_POS_D2 ||
                                 rx_pos == `ISDNF_POS_D3 || rx_pos == `ISDNF_POS_D4)) begin
            echo_r <= rx_bit;
        end
    end

    // Payload capture, most significant bit first.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rx_acc_r <= '0;
        end else if (bit_stb) begin
            if (rx_pos >= `ISDNF_POS_B1A && rx_pos <= `ISDNF_POS_B1A + `ISDNF_OCT_SPAN) begin
                rx_acc_r.b1_first <= {rx_acc_r.b1_first[6:0], rx_bit};
            end else if (rx_pos >= `ISDNF_POS_B2A &&
                         rx_pos <= `ISDNF_POS_B2A + `ISDNF_OCT_SPAN) begin
                rx_acc_r.b2_first <= {rx_acc_r.b2_first[6:0], rx_bit};
            end else if (rx_pos >= `ISDNF_POS_B1B &&
                         rx_pos <= `ISDNF_POS_B1B + `ISDNF_OCT_SPAN) begin
                rx_acc_r.b1_second <= {rx_acc_r.b1_second[6:0], rx_bit};
            end else if (rx_pos >= `ISDNF_POS_B2B &&
                         rx_pos <= `ISDNF_POS_B2B + `ISDNF_OCT_SPAN) begin
                rx_acc_r.b2_second <= {rx_acc_r.b2_second[6:0], rx_bit};
            end else if (rx_pos == `ISDNF_POS_D1 || rx_pos == `ISDNF_POS_D2 ||
                         rx_pos == `ISDNF_POS_D3 || rx_pos == `ISDNF_POS_D4) begin
                rx_acc_r.d <= {rx_acc_r.d[2:0], rx_bit};
            end
        end
    end

    // Hands over each completed frame while aligned.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rx_frame_r <= '0;
            rx_valid_r <= 1'h0;
        end else begin
            rx_valid_r <= 1'h0;
            if (bit_stb && rx_pos == `ISDNF_POS_LAST && rx_state_r == ISDNF_RX_SYNC) begin
                rx_frame_r <= rx_acc_r;
                rx_valid_r <= 1'h1;
            end
        end
    end

    // Outputs straight from flip-flops.
    assign frame_tick = frame_tick_r;
    assign rx_frame   = rx_frame_r;
    assign rx_valid   = rx_valid_r;
    assign rx_sync    = rx_state_r[1];
    assign code_err   = code_err_r;
    assign clk_lost   = clk_lost_r;

    // ****************************************************************
    // Checks.
    // ****************************************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    AST_FRAME_WRAP: assert property (bit_stb && tx_pos_r == `ISDNF_POS_LAST
        |=> tx_pos_r == `ISDNF_POS_FIRST && frame_tick)
        else $error("frame did not wrap after 48 bits");
    AST_POS_RANGE: assert property (tx_pos_r inside {[`ISDNF_POS_FIRST:`ISDNF_POS_LAST]})
        else $error("frame position out of range");
    AST_TICK_CAUSE: assert property (frame_tick
        |-> $past(bit_stb) && $past(tx_pos_r) == `ISDNF_POS_LAST)
        else $error("frame tick without frame end");
    AST_ECHO: assert property (bit_stb && tx_pos_r == `ISDNF_POS_E2
        |-> tx_bit == (rx_acc_r.d[0] & ~ctl_r.echo_zero))
        else $error("echo bit differs from received D bit");
    AST_RESERVED: assert property (bit_stb && (tx_pos_r == `ISDNF_POS_S ||
        (!ctl_r.mf_en && (tx_pos_r == `ISDNF_POS_FA || tx_pos_r == `ISDNF_POS_M))) |-> !tx_bit)
        else $error("reserved or auxiliary bit not zero");
    AST_N_BIT: assert property (bit_stb && tx_pos_r == `ISDNF_POS_N
        |-> tx_bit == !(ctl_r.mf_en && ctl_r.fa))
        else $error("N bit not inverse of FA");
    AST_D_BIT: assert property (bit_stb && tx_pos_r == `ISDNF_POS_D3
        |-> tx_bit == frm_r.d[1])
        else $error("D bit misplaced");
    AST_B1_MSB: assert property (bit_stb && tx_pos_r == `ISDNF_POS_B1A
        |-> tx_bit == frm_r.b1_first[7])
        else $error("B1 octet misplaced");
    AST_ERR_CAUSE: assert property (code_err |-> $past(rx_viol) && !$past(rx_frame_pos))
        else $error("code error without violation");
    AST_LOSS: assert property (!bit_stb [*8] ##1
        (!bit_stb && wd_cnt_r >= 10'(`ISDNF_LOSS_CYC)) |=> clk_lost)
        else $error("lost network clock not flagged");

    COV_FRAME: cover property (bit_stb && tx_pos_r == `ISDNF_POS_LAST);
    COV_SYNC: cover property (rx_state_r == ISDNF_RX_HUNT ##1 rx_state_r == ISDNF_RX_SYNC);
    COV_RXV: cover property (rx_valid);
    COV_ERR: cover property (code_err);
endmodule

/* isdnf_pkg.sv */
package isdnf_pkg;
    // Symbol code handed to the analog front end.
    typedef enum logic [1:0] {
        ISDNF_SYM_NONE = 2'h0,
        ISDNF_SYM_POS  = 2'h1,
        ISDNF_SYM_NEG  = 2'h2
    } isdnf_sym_t;

    // Receive alignment states, one-hot.
    typedef enum logic [1:0] {
        ISDNF_RX_HUNT = 2'h1,
        ISDNF_RX_SYNC = 2'h2
    } isdnf_rxst_t;

    // One outgoing frame's payload.
    typedef struct packed {
        logic [7:0] b1_first;
        logic [7:0] b2_first;
        logic [7:0] b1_second;
        logic [7:0] b2_second;
        logic [3:0] d;
        logic       act;
    } isdnf_txfr_t;

    // One received frame's payload.
    typedef struct packed {
        logic [7:0] b1_first;
        logic [7:0] b2_first;
        logic [7:0] b1_second;
        logic [7:0] b2_second;
        logic [3:0] d;
    } isdnf_rxfr_t;

    // Frame-rate control levels.
    typedef struct packed {
        logic mf_en;
        logic fa;
        logic m;
        logic echo_zero;
    } isdnf_ctl_t;
endpackage

/* isdnf_te_model.sv */
`timescale 1ns/1ps
// ************
// Terminal line model.
// ************
module isdnf_te_model (
    // Timing seen from the network end.
    input  wire logic              net_bclk,
    input  wire logic              frame_tick,
    // Payload and a fault request.
    input  isdnf_pkg::isdnf_rxfr_t te_frame,
    input  wire logic              viol,
    // Line symbol and the frame now on the line.
    output logic [1:0]             line_rx = 2'h0,
    output isdnf_pkg::isdnf_rxfr_t cur
);
    import isdnf_pkg::*;
    logic [5:0]  pos_r   = 6'h00;
    logic [1:48] t       = '1;
    logic        last_r  = 1'b0;
    logic        first_r = 1'b0;
    logic        pol;
    int          p;
    logic        can_detect = 1'b1; // Automatic TEI selection needs source detection.
    logic        src_seen   = 1'b1; // Power source seen across the interface.
    logic        op_pwr     = 1'b1; // Operational or local power present.
    logic        connected;

    // Connection status for management; the line is driven only while connected.
    assign connected = can_detect ? (op_pwr && src_seen) : op_pwr;

    // Builds one frame; each group closes with its own balance bit.
    function automatic logic [1:48] bits(isdnf_rxfr_t f);
        logic [1:48] b;
        int          z;
        b = {2'h0, f.b1_first, 1'h1, f.d[3], 1'h1, 1'h0, 1'h1, f.b2_first, 1'h1,
             f.d[2], 1'h1, f.b1_second, 1'h1, f.d[1], 1'h1, f.b2_second, 1'h1, f.d[0], 1'h1};
        z = 0;
        for (int i = 1; i <= 48; i++) begin
            if (i inside {2, 11, 13, 15, 24, 26, 35, 37, 46, 48}) begin
                b[i] = ~z[0];
                z = 0;
            end else
                z += {31'h0, ~b[i]};
        end
        return b;
    endfunction

    // Frame timing is taken from the frame tick of the network end.
    always @(posedge net_bclk or posedge frame_tick) begin
        if (frame_tick)
            pos_r <= 6'h30;
        else if (pos_r != 6'h00)
            pos_r <= (pos_r == 6'h30) ? 6'h01 : pos_r + 6'h01;
    end

    // Half a bit ahead, drive the bit sampled at the next rise, two bits late.
    always @(negedge net_bclk) begin
        if (pos_r != 6'h00 && connected) begin
            p = (pos_r + 46) % 48 + 1;
            if (p == 1) begin
                cur <= te_frame;
                t = bits(te_frame);
            end
            if (viol && p == 30)
                line_rx <= last_r ? 2'h1 : 2'h2;
            else if (t[p])
                line_rx <= 2'h0;
            else begin
                pol = (p > 2 && first_r) ? last_r : ~last_r;
                first_r <= (p == 2);
                last_r <= pol;
                line_rx <= pol ? 2'h1 : 2'h2;
            end
        end
    end
endmodule

/* tb.sv */
`timescale 1ns/1ps
module tb;
    import isdnf_pkg::*;
    typedef struct packed {
        isdnf_txfr_t tx;
        isdnf_ctl_t  ctl;
        isdnf_rxfr_t te;
    } isdnf_row_t;
    logic        clk      = 1'b0;
    logic        resetn   = 1'b0;
    logic        net_bclk = 1'b0;
    logic        bclk_en  = 1'b1;
    logic        viol     = 1'b0;
    logic        prev_d0  = 1'b1;
    isdnf_txfr_t tx_frame = '0;
    isdnf_ctl_t  tx_ctl   = '0;
    isdnf_rxfr_t te_frame = '0;
    isdnf_rxfr_t cur, rx_frame;
    isdnf_sym_t  line_tx, s0;
    logic [1:0]  line_rx;
    logic        frame_tick, rx_valid, rx_sync, code_err, clk_lost;
    isdnf_row_t  rows [4];
    int          fails = 0, tests_run = 0, cyc = 0, bc = 0, ticks = 0, n_rx = 0, n_err = 0, n;

    isdnf_nt isdnf_nt_i (.clk(clk), .resetn(resetn), .net_bclk(net_bclk), .line_rx(line_rx),
        .line_tx(line_tx), .tx_frame(tx_frame), .tx_ctl(tx_ctl), .frame_tick(frame_tick),
        .rx_frame(rx_frame), .rx_valid(rx_valid), .rx_sync(rx_sync), .code_err(code_err),
        .clk_lost(clk_lost));
    isdnf_te_model isdnf_te_model_i (.net_bclk(net_bclk), .frame_tick(frame_tick),
        .te_frame(te_frame), .viol(viol), .line_rx(line_rx), .cur(cur));

    // Compares and counts.
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: got %0h want %0h", $time, seen, exp);
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Presents the next payloads.
    task automatic load(input isdnf_row_t r);
        tx_frame <= r.tx;
        tx_ctl   <= r.ctl;
        te_frame <= r.te;
    endtask

    // Decodes one transmitted frame, loading the next row before its latch.
    task automatic frame(input isdnf_row_t r, input isdnf_row_t nx);
        logic [1:48] e;
        logic        ez;
        logic        first;
        isdnf_sym_t  s;
        isdnf_sym_t  lastp;
        ez = r.ctl.echo_zero;
        first = 1'b0;
        lastp = ISDNF_SYM_NONE;
        e = {2'h0, r.tx.b1_first, prev_d0 & ~ez, r.tx.d[3], r.tx.act, r.ctl.mf_en & r.ctl.fa,
             ~(r.ctl.mf_en & r.ctl.fa), r.tx.b2_first, r.te.d[3] & ~ez, r.tx.d[2],
             r.ctl.mf_en & r.ctl.m, r.tx.b1_second, r.te.d[2] & ~ez, r.tx.d[1], 1'h0,
             r.tx.b2_second, r.te.d[1] & ~ez, r.tx.d[0], 1'h0};
        e[48] = ~(^(~e[3:47]));
        for (int k = 1; k <= 48; k++) begin
            @(posedge net_bclk);
            @(negedge net_bclk);
            s = line_tx;
            if (k == 47)
                load(nx);
            check(s == ISDNF_SYM_NONE, e[k]);
            if (s != ISDNF_SYM_NONE) begin
                if (k > 1)
                    check(s == lastp, first);
                lastp = s;
                first = (k == 2);
            end
        end
        prev_d0 = r.te.d[0];
    endtask

    // Clock at 25 ns.
    initial begin
        forever #12.5 clk = ~clk;
    end

    // Network bit clock, twenty cycles a bit to keep the run short; run limit.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        bc <= (bc == 9 || !bclk_en) ? 0 : bc + 1;
        if (bclk_en && bc == 9)
            net_bclk <= ~net_bclk;
        if (cyc == 20000) begin
            fails++;
            results();
        end
    end

    // Counts ticks and errors; each delivered frame must match the sent one.
    always @(negedge clk) begin
        ticks += (frame_tick === 1'b1);
        n_err += (code_err === 1'b1);
        if (rx_valid === 1'b1) begin
            n_rx++;
            check(rx_frame, cur);
        end
    end

    // Table rows, then faults, clock loss and a second reset.
    initial begin
        rows[0] = {8'h5A, 8'h0F, 8'hF0, 8'h81, 4'hA, 1'h1, 4'h0, 8'h3C, 8'hC3, 8'h00, 8'hFF, 4'h5};
        rows[1] = {8'hFF, 8'h00, 8'h7E, 8'h01, 4'h3, 1'h0, 4'hE, 8'h01, 8'h80, 8'hAA, 8'h55, 4'hC};
        rows[2] = {8'h00, 8'hFF, 8'h96, 8'h69, 4'h0, 1'h1, 4'hB, 8'hFE, 8'h7F, 8'h0F, 8'hF0, 4'hF};
        rows[3] = {8'hA5, 8'h5A, 8'hC3, 8'h3C, 4'hF, 1'h0, 4'h6, 8'h00, 8'h00, 8'h00, 8'h00, 4'h0};
        repeat (15) @(negedge clk);
        check({line_tx, frame_tick, rx_frame, rx_valid, rx_sync, code_err, clk_lost}, 64'h0);
        @(posedge clk);
        resetn <= 1'b1;
        load(rows[0]);
        n = 0;
        while (frame_tick !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        foreach (rows[i])
            frame(rows[i], rows[(i + 1) % 4]);
        check({ticks[7:0], n_err[7:0], rx_sync, n_rx > 1}, {8'h05, 8'h00, 2'h3});
        @(posedge clk);
        viol <= 1'b1;
        n = 0;
        while (code_err !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        check(code_err, 1'b1);
        @(posedge clk);
        viol <= 1'b0;
        bclk_en <= 1'b0;
        repeat (380) @(negedge clk);
        check(clk_lost, 1'b0);
        s0 = line_tx;
        repeat (60) @(negedge clk);
        check({clk_lost, line_tx}, {1'b1, s0});
        @(posedge clk);
        resetn <= 1'b0;
        repeat (3) @(negedge clk);
        check({line_tx, frame_tick, rx_frame, rx_valid, rx_sync, code_err, clk_lost}, 64'h0);
        results();
    end
endmodule
